// File: hdl/byte_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides, flip-flop storage.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt  = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// File: hdl/cfg_load_if.sv
/*
  Pin bundle between the configuration source and the loading device.
  Assumes the testbench resolves the bidirectional data bus and the
  weakly pulled handshake pin from the enables.
*/
`timescale 1ns/1ps
interface cfg_load_if;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       select_active_low;
  logic       select_active_high;
  logic [7:0] data_from_src;
  logic [7:0] data_from_dev;
  logic       data_dev_oe;
  logic       handshake;
  logic       handshake_oe;
  logic       init_high;
  logic       chain_out;

  modport device (
    input  write_strobe_n, read_strobe_n, select_active_low, select_active_high, data_from_src, init_high,
    output data_from_dev, data_dev_oe, handshake, handshake_oe, chain_out
  );
  modport source (
    output write_strobe_n, read_strobe_n, select_active_low, select_active_high, data_from_src, init_high,
    input  data_from_dev, data_dev_oe, handshake, handshake_oe, chain_out
  );
endinterface

// File: hdl/cfg_load_pkg.sv
/*
  Shared constants for the byte-wide configuration loader: mode straps,
  preamble, timing counts and status byte layout.
  Assumes both ends run on the one configuration clock.
*/
package cfg_load_pkg;
  localparam logic [2:0] MODE_SYNC_PERIPH  = 3'h3;
  localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
  localparam logic [3:0] PREAMBLE_CODE     = 4'h2;
  localparam int         PREAMBLE_BITS     = 4;
  localparam int         LENGTH_BITS       = 24;
  localparam int         BYTE_BITS         = 8;
  localparam int         SYNC_BYTE_EDGES   = 8;
  localparam int         TAIL_EDGES        = 10;
  localparam int         ASYNC_LAST_SHIFT  = 7;
  localparam int         LAST_BIT_IDX      = 6;
  localparam int         STATUS_READY_POS  = 7;
  localparam logic [6:0] STATUS_LOW_BITS   = 7'h7F;
  localparam int         FIFO_DEPTH        = 8;
  localparam int         SAFE_WRITE_GAP    = 11;
  localparam logic [3:0] CNT_ZERO          = 4'h0;
endpackage

// File: hdl/cfg_loader_dev.sv
/*
  Device end: peripheral-mode configuration loader with holding buffer,
  shift register, handshake pin, status read and serial chain output.
  Assumes all pins are synchronous to MCLK, which stands for the
  configuration clock; falling-edge output timing is modelled as a
  one-cycle pipeline stage.
*/
`timescale 1ns/1ps
// Behaviour
// [RL1] source gives byte every eighth edge
// [RL2] sync mode: one-cycle acknowledge per byte
// [RL3] source may ignore the acknowledge
// [RL4] serialize bytes, chain output delayed
// [RL5] source gives ten trailing clock edges
// [RL6] mode 011 selects synchronous peripheral
// [RL7] mode 101 selects asynchronous peripheral
// [RL8] async capture on write condition release
// [RL9] holding buffer feeds shift register
// [RL10] busy low on receipt, high on transfer
// [RL11] write held until ready one cycle
// [RL12] busy two cycles, up to nine
// [RL13] last byte: seven bits, hold bit 6
// [RL14] no polling only with long gaps
// [RL15] status read: ready on D7, rest high
// [RL16] start-up finishes within final write
// [RL17] handshake undriven before init high
// [RL18] stream starts preamble 0010, 24-bit count
module cfg_loader_dev (
  // clock and reset
  input  wire logic  MCLK,
  input  wire logic  SRST,
  // configuration pins
  cfg_load_if.device PINS,
  // mode straps
  input  wire logic  MODE_SELECT_HI,
  input  wire logic  MODE_SELECT_MID,
  input  wire logic  MODE_SELECT_LO,
  // user side
  input  wire logic  LAST_BYTE,
  output logic       SYNC_MODE,
  output logic       ASYNC_MODE,
  output logic       CFG_BIT,
  output logic       CFG_BIT_VALID,
  output logic       PREAMBLE_OK,
  output logic       LOAD_DONE
);
  typedef enum logic [1:0] {M_IDLE, M_SYNC, M_ASYNC, M_OFF} mode_t;

  mode_t      mode_r, mode_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic       hold_full_r, hold_full_nxt;
  logic       hold_last_r, hold_last_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] shift_cnt_r, shift_cnt_nxt;
  logic [3:0] shift_len_r, shift_len_nxt;
  logic [2:0] edge_cnt_r, edge_cnt_nxt;
  logic       wr_act_r, wr_act_nxt;
  logic       hs_r, hs_nxt, hs_oe_r, hs_oe_nxt;
  logic       bit_r, bit_nxt, bit_v_r, bit_v_nxt;
  logic       chain_r, chain_nxt, chain_d_r, chain_d_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic       rd_oe_r, rd_oe_nxt;
  logic [4:0] hdr_cnt_r, hdr_cnt_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic       pre_ok_r, pre_ok_nxt;
  logic       done_r, done_nxt;
  logic       wr_cond, rd_cond, capture, shift_empty, last_shift, hdr_busy;

  assign PINS.handshake     = hs_r;
  assign PINS.handshake_oe  = hs_oe_r;
  assign PINS.chain_out     = chain_d_r;
  assign PINS.data_from_dev = rd_r;
  assign PINS.data_dev_oe   = rd_oe_r;
  assign SYNC_MODE          = (mode_r == M_SYNC);
  assign ASYNC_MODE         = (mode_r == M_ASYNC);
  assign CFG_BIT            = bit_r;
  assign CFG_BIT_VALID      = bit_v_r;
  assign PREAMBLE_OK        = pre_ok_r;
  assign LOAD_DONE          = done_r;

  always_comb begin
    wr_cond = !PINS.write_strobe_n && !PINS.select_active_low
              && PINS.read_strobe_n && PINS.select_active_high;
    rd_cond = PINS.write_strobe_n && !PINS.select_active_low
              && !PINS.read_strobe_n && PINS.select_active_high;
    shift_empty   = (shift_cnt_r == shift_len_r);
    last_shift    = (shift_len_r == 4'(cfg_load_pkg::ASYNC_LAST_SHIFT));
    hdr_busy      = (hdr_cnt_r < 5'(cfg_load_pkg::PREAMBLE_BITS + cfg_load_pkg::LENGTH_BITS));
    mode_nxt      = mode_r;
    hold_nxt      = hold_r;
    hold_full_nxt = hold_full_r;
    hold_last_nxt = hold_last_r;
    shift_nxt     = shift_r;
    shift_cnt_nxt = shift_cnt_r;
    shift_len_nxt = shift_len_r;
    edge_cnt_nxt  = edge_cnt_r;
    wr_act_nxt    = wr_cond;
    hs_oe_nxt     = hs_oe_r;
    hs_nxt        = hs_r;
    bit_nxt       = bit_r;
    bit_v_nxt     = 1'b0;
    chain_nxt     = chain_r;
    chain_d_nxt   = chain_r;
    rd_oe_nxt     = 1'b0;
    rd_nxt        = 8'h00;
    hdr_cnt_nxt   = hdr_cnt_r;
    pre_nxt       = pre_r;
    pre_ok_nxt    = pre_ok_r;
    done_nxt      = done_r;
    capture       = 1'b0;

    // straps are sampled once init is released
    if (mode_r == M_IDLE && PINS.init_high) begin
      unique case ({MODE_SELECT_HI, MODE_SELECT_MID, MODE_SELECT_LO})
        cfg_load_pkg::MODE_SYNC_PERIPH: begin
          // no stale high before the first acknowledge
          mode_nxt = M_SYNC; // RL6
          hs_nxt   = 1'b0;   // RL2
        end
        cfg_load_pkg::MODE_ASYNC_PERIPH: mode_nxt = M_ASYNC; // RL7
        default:                         mode_nxt = M_OFF;
      endcase
    end
    hs_oe_nxt = PINS.init_high; // RL17

    unique case (mode_r)
      M_SYNC: begin
        // byte taken on every eighth edge, acknowledge for one cycle
        edge_cnt_nxt = edge_cnt_r + 3'h1;
        capture      = (edge_cnt_r == 3'h0) && !done_r; // RL1
        hs_nxt       = capture; // RL2
        if (capture) begin
          hold_nxt      = PINS.data_from_src;
          hold_full_nxt = 1'b1;
          hold_last_nxt = LAST_BYTE;
        end
      end
      M_ASYNC: begin
        // trailing edge of the write condition
        capture = wr_act_r && !wr_cond && !hold_full_r; // RL8
        if (capture) begin
          hold_nxt      = PINS.data_from_src;
          hold_full_nxt = 1'b1;
          hold_last_nxt = LAST_BYTE;
        end
      end
      default: begin
      end
    endcase

    // serializer: lsb first, so a cut last byte rests on its bit 6
    if (!shift_empty) begin
      bit_nxt       = shift_r[0];
      bit_v_nxt     = 1'b1;
      shift_nxt     = {1'b1, shift_r[7:1]};
      shift_cnt_nxt = shift_cnt_r + 4'h1; // RL9
      // header and the final async byte are forwarded, frames are not
      chain_nxt     = (hdr_busy || last_shift) ? shift_r[0] : 1'b1; // RL4 RL13
      if (hdr_busy) begin
        hdr_cnt_nxt = hdr_cnt_r + 5'h1;
      end
      if (hdr_cnt_r < 5'(cfg_load_pkg::PREAMBLE_BITS)) begin
        pre_nxt = {pre_r[2:0], shift_r[0]};
      end
      if (hdr_cnt_r == 5'(cfg_load_pkg::PREAMBLE_BITS)) begin
        pre_ok_nxt = (pre_r == cfg_load_pkg::PREAMBLE_CODE); // RL18
      end
    end
    // reload on the last bit, else sync bytes eight edges apart overrun
    if (hold_full_r && (shift_empty || (shift_cnt_r + 4'h1) == shift_len_r)) begin
      shift_nxt     = hold_r;
      shift_cnt_nxt = cfg_load_pkg::CNT_ZERO;
      shift_len_nxt = (hold_last_r && mode_r == M_ASYNC) ? 4'(cfg_load_pkg::ASYNC_LAST_SHIFT)
                                                         : 4'(cfg_load_pkg::BYTE_BITS); // RL13
      hold_full_nxt = capture; // RL9
      done_nxt      = hold_last_r; // RL16
    end
    if (mode_r == M_ASYNC) begin
      // ready only a cycle after the move: busy lasts two periods at least
      hs_nxt = !hold_full_r && !hold_full_nxt; // RL10 RL12
      if (rd_cond) begin
        rd_oe_nxt = 1'b1;
        rd_nxt    = {hs_nxt, cfg_load_pkg::STATUS_LOW_BITS}; // RL15
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mode_r      <= M_IDLE;
      hold_r      <= 8'h00;
      hold_full_r <= 1'b0;
      hold_last_r <= 1'b0;
      shift_r     <= 8'hFF;
      shift_cnt_r <= 4'h8;
      shift_len_r <= 4'h8;
      edge_cnt_r  <= 3'h0;
      wr_act_r    <= 1'b0;
      hs_r        <= 1'b1;
      hs_oe_r     <= 1'b0;
      bit_r       <= 1'b1;
      bit_v_r     <= 1'b0;
      chain_r     <= 1'b1;
      chain_d_r   <= 1'b1;
      rd_r        <= 8'h00;
      rd_oe_r     <= 1'b0;
      hdr_cnt_r   <= 5'h00;
      pre_r       <= 4'h0;
      pre_ok_r    <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      hold_r      <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      hold_last_r <= hold_last_nxt;
      shift_r     <= shift_nxt;
      shift_cnt_r <= shift_cnt_nxt;
      shift_len_r <= shift_len_nxt;
      edge_cnt_r  <= edge_cnt_nxt;
      wr_act_r    <= wr_act_nxt;
      hs_r        <= hs_nxt;
      hs_oe_r     <= hs_oe_nxt;
      bit_r       <= bit_nxt;
      bit_v_r     <= bit_v_nxt;
      chain_r     <= chain_nxt;
      chain_d_r   <= chain_d_nxt;
      rd_r        <= rd_nxt;
      rd_oe_r     <= rd_oe_nxt;
      hdr_cnt_r   <= hdr_cnt_nxt;
      pre_r       <= pre_nxt;
      pre_ok_r    <= pre_ok_nxt;
      done_r      <= done_nxt;
    end
  end
endmodule

// File: hdl/cfg_source_ctl.sv
/*
  Source end: feeds configuration bytes from a FIFO to the device, either
  byte-per-eight-edges (synchronous) or by strobed writes with handshake.
  Assumes the device pins are synchronous to MCLK.
*/
`timescale 1ns/1ps
module cfg_source_ctl (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       SRST,
  // pins toward device
  cfg_load_if.source      PINS,
  // user side
  input  wire logic       ASYNC_SEL,
  input  wire logic       START,
  input  wire logic       BYTE_VALID,
  output logic            BYTE_READY,
  input  wire logic [7:0] BYTE_DATA,
  input  wire logic       BYTE_LAST,
  output logic            TAIL_DONE
);
  typedef enum logic [2:0] {S_IDLE, S_FEED, S_WAIT_RDY, S_HOLD, S_TAIL, S_DONE} st_t;

  st_t        st_r, st_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic       ws_n_r, ws_n_nxt, init_r, init_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic       last_r, last_nxt, done_r, done_nxt;
  logic       f_valid, f_ready, f_last;
  logic [7:0] f_data;

  byte_fifo #(.WIDTH(9), .DEPTH(cfg_load_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst       (SRST),
    .in_valid  (BYTE_VALID),
    .in_ready  (BYTE_READY),
    .in_data   ({BYTE_LAST, BYTE_DATA}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  ({f_last, f_data})
  );

  assign PINS.write_strobe_n     = ws_n_r;
  assign PINS.read_strobe_n      = 1'b1;
  assign PINS.select_active_low  = 1'b0;
  assign PINS.select_active_high = 1'b1;
  assign PINS.data_from_src      = dat_r;
  assign PINS.init_high          = init_r;
  assign TAIL_DONE               = done_r;

  always_comb begin
    st_nxt   = st_r;
    dat_nxt  = dat_r;
    ws_n_nxt = ws_n_r;
    init_nxt = init_r;
    cnt_nxt  = cnt_r;
    last_nxt = last_r;
    done_nxt = done_r;
    f_ready  = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        if (START) begin
          init_nxt = 1'b1;
          st_nxt   = S_FEED;
          cnt_nxt  = 4'h0;
        end
      end
      S_FEED: begin
        // sync: byte set one edge ahead of each device capture; ack not watched
        if (!ASYNC_SEL) begin
          cnt_nxt = (cnt_r == 4'(cfg_load_pkg::SYNC_BYTE_EDGES - 1)) ? 4'h0 : cnt_r + 4'h1; // RL1 RL3
          if (cnt_r == cfg_load_pkg::CNT_ZERO && f_valid) begin
            f_ready  = 1'b1;
            dat_nxt  = f_data;
            last_nxt = f_last;
          end
          if (cnt_r == 4'h1 && last_r) begin
            st_nxt  = S_TAIL;
            cnt_nxt = 4'h0;
          end
        end else if (f_valid) begin
          // a write may open while the previous byte is still busy
          f_ready  = 1'b1;
          dat_nxt  = f_data;
          last_nxt = f_last;
          ws_n_nxt = 1'b0;
          st_nxt   = S_WAIT_RDY;
        end
      end
      S_WAIT_RDY: begin
        if (PINS.handshake) begin
          st_nxt = S_HOLD; // RL11
        end
      end
      S_HOLD: begin
        // ready seen high one full cycle before the write ends
        if (PINS.handshake) begin
          ws_n_nxt = 1'b1; // RL11 RL14
          st_nxt   = last_r ? S_TAIL : S_FEED; // RL16
          cnt_nxt  = 4'h0;
        end else begin
          st_nxt = S_WAIT_RDY;
        end
      end
      S_TAIL: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'(cfg_load_pkg::TAIL_EDGES - 1)) begin
          st_nxt   = S_DONE; // RL5
          done_nxt = 1'b1;
        end
      end
      S_DONE: begin
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_r   <= S_IDLE;
      dat_r  <= 8'h00;
      ws_n_r <= 1'b1;
      init_r <= 1'b0;
      cnt_r  <= 4'h0;
      last_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      dat_r  <= dat_nxt;
      ws_n_r <= ws_n_nxt;
      init_r <= init_nxt;
      cnt_r  <= cnt_nxt;
      last_r <= last_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

// File: verification/cfg_link_monitor.sv
/*
  Checker on the pins between source end and device end.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cfg_link_monitor (
  // clock and reset
  input wire logic       MCLK,
  input wire logic       SRST,
  // pins
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       select_active_low,
  input wire logic       select_active_high,
  input wire logic [7:0] data_from_src,
  input wire logic [7:0] data_from_dev,
  input wire logic       data_dev_oe,
  input wire logic       handshake,
  input wire logic       handshake_oe,
  input wire logic       init_high,
  input wire logic       chain_out
);
  logic wcond;
  logic rcond;
  assign wcond = !write_strobe_n && !select_active_low && select_active_high && read_strobe_n;
  assign rcond = !read_strobe_n && write_strobe_n && !select_active_low && select_active_high;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  property p_hs_float;
    !init_high |-> !handshake_oe;
  endproperty
  a_hs_float: assert property (p_hs_float) else $error("handshake driven early");
  property p_chain_idle;
    !init_high |-> chain_out;
  endproperty
  a_chain_idle: assert property (p_chain_idle) else $error("chain not idle high");
  property p_stat_quiet;
    !rcond && !$past(rcond) |-> !data_dev_oe;
  endproperty
  a_stat_quiet: assert property (p_stat_quiet) else $error("data bus driven without read");
  // busy: low two periods after capture, back high within nine
  property p_busy;
    $fell(wcond) |-> ##1 !handshake[*2] ##[1:7] handshake;
  endproperty
  a_busy: assert property (p_busy) else $error("busy interval wrong");
  property p_ws_release;
    $rose(write_strobe_n) |-> $past(handshake);
  endproperty
  a_ws_release: assert property (p_ws_release) else $error("write ended while busy");
  property p_ws_data;
    !write_strobe_n && $past(!write_strobe_n) |-> $stable(data_from_src);
  endproperty
  a_ws_data: assert property (p_ws_data) else $error("data moved during write");
  property p_ws_select;
    !write_strobe_n |-> !select_active_low && select_active_high && read_strobe_n;
  endproperty
  a_ws_select: assert property (p_ws_select) else $error("write without selects");
  property p_ws_init;
    !write_strobe_n |-> init_high;
  endproperty
  a_ws_init: assert property (p_ws_init) else $error("write before init");
  c_write: cover property ($fell(wcond));
  c_init: cover property ($rose(init_high));
  c_busy: cover property ($fell(handshake));
endmodule

// File: verification/tb.sv
/*
  Bench: source and device joined by the pin bundle, plus a second
  device whose pins the bench drives itself.
  Assumes the design files under hdl/ are compiled first.
*/
`timescale 1ns/1ps
module tb;
  localparam int NB = 10;
  logic       MCLK = 1'b0;
  logic       SRST = 1'b1;
  logic       async_sel = 1'b1;
  logic       start = 1'b0;
  logic       bvalid = 1'b0;
  logic       blast = 1'b0;
  logic [7:0] bdata = 8'h00;
  logic [2:0] mode = 3'h5;
  logic       bready, tail_done, last_byte, sync_mode, async_mode;
  logic       cfg_bit, cfg_valid, pre_ok, load_done, valid2, ws_q, hs_pin, hs2_pin;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         nbit, nev, nhi, n2, k;
  logic [7:0] stream [NB] = '{8'hF4, 8'hFF, 8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h00, 8'hFF, 8'h5A, 8'h83};
  cfg_load_if link();
  cfg_load_if lnk2();
  always #2 MCLK = ~MCLK;
  // weak pull-up on the handshake pin
  assign hs_pin = link.handshake_oe ? link.handshake : 1'b1;
  assign hs2_pin = lnk2.handshake_oe ? lnk2.handshake : 1'b1;
  assign last_byte = async_sel ? (nev >= NB) : (nhi >= NB - 1);
  cfg_source_ctl cfg_source_ctl_i (.MCLK(MCLK), .SRST(SRST), .PINS(link.source), .ASYNC_SEL(async_sel),
    .START(start), .BYTE_VALID(bvalid), .BYTE_READY(bready), .BYTE_DATA(bdata), .BYTE_LAST(blast),
    .TAIL_DONE(tail_done));
  cfg_loader_dev cfg_loader_dev_i (.MCLK(MCLK), .SRST(SRST), .PINS(link.device), .MODE_SELECT_HI(mode[2]),
    .MODE_SELECT_MID(mode[1]), .MODE_SELECT_LO(mode[0]), .LAST_BYTE(last_byte), .SYNC_MODE(sync_mode),
    .ASYNC_MODE(async_mode), .CFG_BIT(cfg_bit), .CFG_BIT_VALID(cfg_valid), .PREAMBLE_OK(pre_ok),
    .LOAD_DONE(load_done));
  cfg_loader_dev cfg_loader_dev_i2 (.MCLK(MCLK), .SRST(SRST), .PINS(lnk2.device), .MODE_SELECT_HI(1'b1),
    .MODE_SELECT_MID(1'b0), .MODE_SELECT_LO(1'b1), .LAST_BYTE(1'b0), .SYNC_MODE(), .ASYNC_MODE(),
    .CFG_BIT(), .CFG_BIT_VALID(valid2), .PREAMBLE_OK(), .LOAD_DONE());
  cfg_link_monitor cfg_link_monitor_i (.MCLK(MCLK), .SRST(SRST), .write_strobe_n(link.write_strobe_n),
    .read_strobe_n(link.read_strobe_n), .select_active_low(link.select_active_low),
    .select_active_high(link.select_active_high), .data_from_src(link.data_from_src),
    .data_from_dev(link.data_from_dev), .data_dev_oe(link.data_dev_oe), .handshake(link.handshake),
    .handshake_oe(link.handshake_oe), .init_high(link.init_high), .chain_out(link.chain_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bit stream, write ends and ack cycles, sampled where settled
  always @(negedge MCLK) begin
    if (SRST === 1'b1) begin
      nbit = 0;
      nev = 0;
      nhi = 0;
    end else begin
      if (cfg_valid === 1'b1) begin
        check(cfg_bit, stream[nbit / 8][nbit % 8]);
        nbit++;
      end
      if (link.write_strobe_n === 1'b1 && ws_q === 1'b0)
        nev++;
      if (sync_mode === 1'b1 && hs_pin === 1'b1)
        nhi++;
    end
    if (valid2 === 1'b1)
      n2++;
    ws_q = link.write_strobe_n;
  end

  task automatic push(input logic [7:0] d, input logic l);
    bvalid = 1'b1;
    bdata = d;
    blast = l;
    for (k = 0; k < 3000 && bready !== 1'b1; k++)
      @(negedge MCLK);
    if (k == 3000) begin
      n_fail++;
      tally_and_finish();
    end
    // valid stays up; the caller drops it after the last byte
    @(negedge MCLK);
  endtask

  task automatic run(input logic asy);
    SRST = 1'b1;
    async_sel = asy;
    mode = asy ? 3'h5 : 3'h3;
    start = 1'b0;
    repeat (3) @(negedge MCLK);
    SRST = 1'b0;
    for (int i = 0; i < 8; i++)
      push(stream[i], 1'b0);
    check(bready, 1'b0);
    start = 1'b1;
    push(stream[8], 1'b0);
    push(stream[9], 1'b1);
    bvalid = 1'b0;
    for (k = 0; k < 3000 && !(load_done === 1'b1 && (asy || tail_done === 1'b1)); k++)
      @(negedge MCLK);
    if (k == 3000) begin
      n_fail++;
      tally_and_finish();
    end
    repeat (30) @(negedge MCLK);
    check({async_mode, sync_mode}, asy ? 2'h2 : 2'h1);
    check(pre_ok, 1'b1);
    check(nbit, asy ? 8 * NB - 1 : 8 * NB);
    if (asy)
      check(link.chain_out, stream[NB - 1][6]);
    else
      check(nhi, NB);
  endtask

  task automatic wr2(input logic [7:0] d);
    @(negedge MCLK);
    lnk2.write_strobe_n = 1'b0;
    lnk2.data_from_src = d;
    @(negedge MCLK);
    lnk2.write_strobe_n = 1'b1;
  endtask

  task automatic rd2(input logic [7:0] exp);
    @(negedge MCLK);
    lnk2.read_strobe_n = 1'b0;
    repeat (2) @(negedge MCLK);
    check({lnk2.data_dev_oe, lnk2.data_from_dev}, {1'b1, exp});
    lnk2.read_strobe_n = 1'b1;
  endtask

  initial begin
    lnk2.write_strobe_n = 1'b1;
    lnk2.read_strobe_n = 1'b1;
    lnk2.select_active_low = 1'b0;
    lnk2.select_active_high = 1'b1;
    lnk2.data_from_src = 8'h00;
    lnk2.init_high = 1'b0;
    n2 = 0;
    repeat (3) @(negedge MCLK);
    SRST = 1'b0;
    repeat (2) @(negedge MCLK);
    check({hs2_pin, lnk2.handshake_oe}, 2'h2);
    lnk2.init_high = 1'b1;
    repeat (4) @(negedge MCLK);
    rd2(8'hFF);
    wr2(8'h2F);
    repeat (3) @(negedge MCLK);
    wr2(8'hFF);
    // third write lands while the holding buffer is still full
    wr2(8'h00);
    rd2(8'h7F);
    repeat (30) @(negedge MCLK);
    rd2(8'hFF);
    check(n2, 16);
    run(1'b1);
    run(1'b0);
    tally_and_finish();
  end
endmodule
